// ===== common/ddim_pkg.sv
`default_nettype none
// ============================================================
// Shared constants of the descriptor-done interrupt mask block
// ============================================================
package ddim_pkg;
   // Descriptor slots per list; one mask bit per slot.
   localparam int unsigned SLOT_COUNT    = 32;
   // Number of lists: isochronous, periodic interrupt and asynchronous.
   localparam int unsigned LIST_COUNT    = 3;
   // Number of group mask registers (an OR and an AND mask per list).
   localparam int unsigned MASK_COUNT    = 6;
   // Least address width accepted; it matches the 12-bit register offsets.
   localparam int unsigned MIN_ADDR_W    = 12;
   // Byte offsets of the registers on the bus.
   localparam logic [11:0] OFF_ISO_OR       = 12'h318;
   localparam logic [11:0] OFF_PERIODIC_OR  = 12'h31c;
   localparam logic [11:0] OFF_ASYNC_OR     = 12'h320;
   localparam logic [11:0] OFF_ISO_AND      = 12'h324;
   localparam logic [11:0] OFF_PERIODIC_AND = 12'h328;
   localparam logic [11:0] OFF_ASYNC_AND    = 12'h32c;
   localparam logic [11:0] OFF_IRQ_ENABLE   = 12'h330;
   localparam logic [11:0] OFF_IRQ_STATUS   = 12'h334;
   localparam logic [11:0] OFF_IRQ_MASK     = 12'h338;
   // Word shift from byte address to word index.
   localparam int unsigned WORD_SHIFT    = 2;
   // Register select codes: the word index counted from the first register.
   localparam logic [3:0]  SEL_OR_BASE   = 4'h0;
   localparam logic [3:0]  SEL_AND_BASE  = 4'h3;
   localparam logic [3:0]  SEL_ENABLE    = 4'h6;
   localparam logic [3:0]  SEL_STATUS    = 4'h7;
   localparam logic [3:0]  SEL_IRQ_MASK  = 4'h8;
   localparam logic [3:0]  SEL_NONE      = 4'hf;
   // Reset value of every mask.
   localparam logic [31:0] MASK_RESET    = 32'h0000_0000;
   // Per-list enable, status and mask bit: list 0 iso, 1 periodic, 2 async.
   localparam int unsigned LIST_BIT [LIST_COUNT] = '{9, 7, 8};
   // Implemented bits of the enable, status and interrupt mask registers.
   localparam logic [31:0] EVENT_BITS    = 32'h0000_0380;
   // AXI responses.
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : ddim_pkg
`default_nettype wire

// ===== hdl/ddim_top.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Descriptor-done interrupt grouping masks
// ============================================================
module ddim_top #(
   parameter int unsigned ADDR_W = 12      // Width of the bus address.
) (
   input  wire logic              CLK_SYS,
   input  wire logic              RST_N,
   input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic [2:0]        S_AXI_AWPROT,
   input  wire logic              S_AXI_AWVALID,
   output logic                   S_AXI_AWREADY,
   input  wire logic [31:0]       S_AXI_WDATA,
   input  wire logic [3:0]        S_AXI_WSTRB,
   input  wire logic              S_AXI_WVALID,
   output logic                   S_AXI_WREADY,
   output logic [1:0]             S_AXI_BRESP,
   output logic                   S_AXI_BVALID,
   input  wire logic              S_AXI_BREADY,
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic [2:0]        S_AXI_ARPROT,
   input  wire logic              S_AXI_ARVALID,
   output logic                   S_AXI_ARREADY,
   output logic [31:0]            S_AXI_RDATA,
   output logic [1:0]             S_AXI_RRESP,
   output logic                   S_AXI_RVALID,
   input  wire logic              S_AXI_RREADY,
   input  wire logic [31:0]       DONE_ISO,
   input  wire logic [31:0]       DONE_PERIODIC,
   input  wire logic [31:0]       DONE_ASYNC,
   output logic                   IRQ
);

   // ============================================================
   // Elaboration checks
   // ============================================================
   // The address must be wide enough to reach the last register.
   if (ADDR_W < ddim_pkg::MIN_ADDR_W) begin : g_bad_addr_w
      $error("ADDR_W too small to reach the register map.");
   end

   // ============================================================
   // Declarations
   // ============================================================
   logic [31:0]       mask_bank [ddim_pkg::MASK_COUNT];  // OR masks, then AND masks.
   logic [31:0]       irq_enable;       // Per-list interrupt enables.
   logic [31:0]       irq_status;       // Sticky per-list done events.
   logic [31:0]       irq_mask;         // Per-list gate onto the interrupt line.
   logic              aw_held;          // A write address waits.
   logic              w_held;           // Write data wait.
   logic [ADDR_W-1:0] wr_addr;          // Latched write address.
   logic [31:0]       wr_data;          // Latched write data.
   logic [3:0]        wr_strb;          // Latched byte strobes.
   logic              next_aw_held;     // Next value of aw_held.
   logic              next_w_held;      // Next value of w_held.
   logic              next_bvalid;      // Next value of the write response valid.
   logic              next_rvalid;      // Next value of the read data valid.
   logic              wr_fire;          // Both halves of a write are present.
   logic              ar_fire;          // A read address is taken.
   logic [3:0]        wr_sel;           // Register selected by the write.
   logic [3:0]        rd_sel;           // Register selected by the read.
   logic [31:0]       wr_bits;          // Write data merged over strobes.
   logic [31:0]       wr_lanes;         // Bit-wide strobe expansion.
   logic [31:0]       rd_value;         // Word returned for the read.
   logic [31:0]       set_vec;          // Status bits raised this cycle.
   logic [ddim_pkg::LIST_COUNT-1:0] list_match;  // Per-list mask combination met.
   logic [31:0]       done_map [ddim_pkg::LIST_COUNT];  // Done maps by list.

   // Keep the iso, periodic, async order of the list index.
   assign done_map[0] = DONE_ISO;
   assign done_map[1] = DONE_PERIODIC;
   assign done_map[2] = DONE_ASYNC;

   // Named views of the six masks.
   wire logic [31:0] iso_or_group_mask       = mask_bank[0];
   wire logic [31:0] periodic_or_group_mask  = mask_bank[1];
   wire logic [31:0] async_or_group_mask     = mask_bank[2];
   wire logic [31:0] iso_and_group_mask      = mask_bank[3];
   wire logic [31:0] periodic_and_group_mask = mask_bank[4];
   wire logic [31:0] async_and_group_mask    = mask_bank[5];

   // ============================================================
   // Address decode
   // ============================================================
   // Maps a byte address onto a register select code, or none when unmapped.
   function automatic logic [3:0] reg_select(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] rel;
      rel = a - ADDR_W'(ddim_pkg::OFF_ISO_OR);
      reg_select = ddim_pkg::SEL_NONE;
      if (a[ddim_pkg::WORD_SHIFT-1:0] == '0 && a >= ADDR_W'(ddim_pkg::OFF_ISO_OR) &&
          a <= ADDR_W'(ddim_pkg::OFF_IRQ_MASK)) begin
         reg_select = 4'(rel >> ddim_pkg::WORD_SHIFT);
      end
   endfunction : reg_select

   assign wr_sel = reg_select(wr_addr);
   assign rd_sel = reg_select(S_AXI_ARADDR);

   // ============================================================
   // AXI4-Lite handshake
   // ============================================================
   assign wr_fire = aw_held && w_held && !S_AXI_BVALID;
   assign ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;

   // Next handshake state; address and data are taken in either order.
   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_bvalid  = S_AXI_BVALID;
      next_rvalid  = S_AXI_RVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         next_aw_held = 1'b1;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         next_w_held = 1'b1;
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
         next_bvalid = 1'b0;
      end
      if (ar_fire) begin
         next_rvalid = 1'b1;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         next_rvalid = 1'b0;
      end
   end

   // Handshake flops; readies are low while a write or read is under way.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_ARREADY <= 1'b0;
      end else begin
         aw_held       <= next_aw_held;
         w_held        <= next_w_held;
         S_AXI_BVALID  <= next_bvalid;
         S_AXI_RVALID  <= next_rvalid;
         S_AXI_AWREADY <= !next_aw_held && !next_bvalid;
         S_AXI_WREADY  <= !next_w_held && !next_bvalid;
         S_AXI_ARREADY <= !next_rvalid;
      end
   end

   // Latch the write address and data when each is taken.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         wr_addr <= '0;
         wr_data <= 32'h0;
         wr_strb <= 4'h0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            wr_addr <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            wr_data <= S_AXI_WDATA;
            wr_strb <= S_AXI_WSTRB;
         end
      end
   end

   // Write response: unmapped addresses answer with a slave error.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_BRESP <= ddim_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         S_AXI_BRESP <= (wr_sel == ddim_pkg::SEL_NONE) ? ddim_pkg::RESP_SLVERR
                                                       : ddim_pkg::RESP_OKAY;
      end
   end

   // Expand byte strobes to bit lanes, one byte per loop pass.
   for (genvar b = 0; b < 4; b++) begin : g_lane
      assign wr_lanes[8*b +: 8] = {8{wr_strb[b]}};
   end

   // ============================================================
   // Mask registers
   // ============================================================
   // Each mask is written over the strobed lanes and clears to zero.
   for (genvar m = 0; m < ddim_pkg::MASK_COUNT; m++) begin : g_mask
      always_ff @(posedge CLK_SYS or negedge RST_N) begin
         if (!RST_N) begin
            mask_bank[m] <= ddim_pkg::MASK_RESET;
         end else if (wr_fire && wr_sel == 4'(m)) begin
            mask_bank[m] <= (mask_bank[m] & ~wr_lanes) | wr_bits;
         end
      end
   end

   assign wr_bits = wr_data & wr_lanes;

   // ============================================================
   // Done map grouping
   // ============================================================
   // Each list meets its combination when any OR slot is done, or all AND
   // slots are done with at least one AND slot chosen.
   for (genvar g = 0; g < ddim_pkg::LIST_COUNT; g++) begin : g_list
      wire logic [31:0] or_m  = mask_bank[g];
      wire logic [31:0] and_m = mask_bank[g + ddim_pkg::LIST_COUNT];
      // A clear bit takes its slot out of that mask's condition.
      assign list_match[g] = (|(done_map[g] & or_m)) ||
                             ((|and_m) && ((done_map[g] & and_m) == and_m));
   end

   // Raise the list's status bit only while its enable is set.
   always_comb begin
      set_vec = 32'h0;
      for (int i = 0; i < ddim_pkg::LIST_COUNT; i++) begin
         set_vec[ddim_pkg::LIST_BIT[i]] = list_match[i] &&
                                          irq_enable[ddim_pkg::LIST_BIT[i]];
      end
   end

   // ============================================================
   // Interrupt registers
   // ============================================================
   // Enable and interrupt mask hold only the three list bits.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         irq_enable <= 32'h0;
         irq_mask   <= 32'h0;
      end else if (wr_fire) begin
         if (wr_sel == ddim_pkg::SEL_ENABLE) begin
            irq_enable <= ((irq_enable & ~wr_lanes) | wr_bits) & ddim_pkg::EVENT_BITS;
         end
         if (wr_sel == ddim_pkg::SEL_IRQ_MASK) begin
            irq_mask <= ((irq_mask & ~wr_lanes) | wr_bits) & ddim_pkg::EVENT_BITS;
         end
      end
   end

   // Sticky status, cleared by writing ones; a new event wins over the clear.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         irq_status <= 32'h0;
      end else if (wr_fire && wr_sel == ddim_pkg::SEL_STATUS) begin
         irq_status <= (irq_status & ~wr_bits) | set_vec;
      end else begin
         irq_status <= irq_status | set_vec;
      end
   end

   // Interrupt line: high while an enabled, unmasked status bit is set.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_status & irq_mask & irq_enable);
      end
   end

   // ============================================================
   // Read path
   // ============================================================
   // Select the word to return; unmapped addresses read as zero.
   always_comb begin
      rd_value = 32'h0;
      if (rd_sel < 4'(ddim_pkg::MASK_COUNT)) begin
         rd_value = mask_bank[rd_sel[2:0]];
      end else if (rd_sel == ddim_pkg::SEL_ENABLE) begin
         rd_value = irq_enable;
      end else if (rd_sel == ddim_pkg::SEL_STATUS) begin
         rd_value = irq_status;
      end else if (rd_sel == ddim_pkg::SEL_IRQ_MASK) begin
         rd_value = irq_mask;
      end
   end

   // Capture the read answer when the address is taken.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_RDATA <= 32'h0;
         S_AXI_RRESP <= ddim_pkg::RESP_OKAY;
      end else if (ar_fire) begin
         S_AXI_RDATA <= rd_value;
         S_AXI_RRESP <= (rd_sel == ddim_pkg::SEL_NONE) ? ddim_pkg::RESP_SLVERR
                                                       : ddim_pkg::RESP_OKAY;
      end
   end

   // ============================================================
   // Assertions
   // ============================================================
   default clocking ddim_cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   // Marks the first cycle after reset release.
   logic out_of_reset;
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         out_of_reset <= 1'b0;
      end else begin
         out_of_reset <= 1'b1;
      end
   end

   // A full-word write to a given select.
   sequence full_write(logic [3:0] sel);
      wr_fire && wr_sel == sel && wr_strb == 4'hf;
   endsequence

   masks_reset_a : assert property (
      !out_of_reset |-> (iso_or_group_mask == ddim_pkg::MASK_RESET &&
                         periodic_or_group_mask == ddim_pkg::MASK_RESET &&
                         async_or_group_mask == ddim_pkg::MASK_RESET &&
                         iso_and_group_mask == ddim_pkg::MASK_RESET &&
                         periodic_and_group_mask == ddim_pkg::MASK_RESET &&
                         async_and_group_mask == ddim_pkg::MASK_RESET))
      else $error("Masks not zero after reset.");
   iso_or_write_a : assert property (
      full_write(4'h0) |=> iso_or_group_mask == $past(wr_data))
      else $error("Isochronous OR mask write lost.");
   per_or_write_a : assert property (
      full_write(4'h1) |=> periodic_or_group_mask == $past(wr_data))
      else $error("Periodic OR mask write lost.");
   async_or_write_a : assert property (
      full_write(4'h2) |=> async_or_group_mask == $past(wr_data))
      else $error("Asynchronous OR mask write lost.");
   iso_and_write_a : assert property (
      full_write(4'h3) |=> iso_and_group_mask == $past(wr_data))
      else $error("Isochronous AND mask write lost.");
   per_and_write_a : assert property (
      full_write(4'h4) |=> periodic_and_group_mask == $past(wr_data))
      else $error("Periodic AND mask write lost.");
   async_and_write_a : assert property (
      full_write(4'h5) |=> async_and_group_mask == $past(wr_data))
      else $error("Asynchronous AND mask write lost.");
   empty_mask_quiet_a : assert property (
      (iso_or_group_mask == 32'h0 && iso_and_group_mask == 32'h0) |-> !list_match[0])
      else $error("Isochronous match with empty masks.");
   or_hit_match_a : assert property (
      (|(DONE_ASYNC & async_or_group_mask)) |-> list_match[2])
      else $error("Asynchronous OR hit not matched.");
   and_miss_a : assert property (
      (periodic_or_group_mask == 32'h0 &&
       (DONE_PERIODIC & periodic_and_group_mask) != periodic_and_group_mask) |->
         !list_match[1])
      else $error("Periodic AND matched with slots pending.");
   iso_event_set_a : assert property (
      (list_match[0] && irq_enable[ddim_pkg::LIST_BIT[0]]) |=>
         irq_status[ddim_pkg::LIST_BIT[0]])
      else $error("Isochronous event not recorded.");
   no_enable_quiet_a : assert property (
      (!irq_enable[ddim_pkg::LIST_BIT[2]] && !irq_status[ddim_pkg::LIST_BIT[2]]) |=>
         !irq_status[ddim_pkg::LIST_BIT[2]])
      else $error("Asynchronous status set while disabled.");
   irq_follow_a : assert property (
      IRQ == $past(|(irq_status & irq_mask & irq_enable)))
      else $error("Interrupt line does not follow gated status.");
   resp_hold_a : assert property (
      (S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("Write response dropped before taken.");

endmodule : ddim_top
`default_nettype wire

// ===== verif/descriptor_done_irq_masks_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Self-checking bench of the descriptor-done grouping masks
// ==========================================================
module descriptor_done_irq_masks_tb;
   logic        clk;        // System clock, 4 ns period.
   logic        rst_n;      // Active-low reset.
   logic [11:0] awaddr;     // Write address.
   logic        awvalid;    // Write address valid.
   logic        aw_rdy;     // Write address ready.
   logic [31:0] wdata;      // Write data.
   logic [3:0]  wstrb;      // Write byte strobes.
   logic        wvalid;     // Write data valid.
   logic        w_rdy;      // Write data ready.
   logic [1:0]  bresp;      // Write response.
   logic        bvalid;     // Write response valid.
   logic        bready;     // Write response ready.
   logic [11:0] araddr;     // Read address.
   logic        arvalid;    // Read address valid.
   logic        ar_rdy;     // Read address ready.
   logic [31:0] rdata;      // Read data.
   logic [1:0]  rresp;      // Read response.
   logic        rvalid;     // Read data valid.
   logic        rready;     // Read data ready.
   logic [31:0] done [3];   // Done maps: iso, periodic, async.
   logic        irq;        // Interrupt request.
   logic [31:0] seed;       // Random generator state.
   logic [31:0] rdv;        // Last read word.
   logic [1:0]  rsp;        // Last response code.
   int          miscompares;
   int          tests_run;
   int          cycles;     // Clock cycles since start.
   // Mask offsets: OR masks of the three lists, then their AND masks.
   localparam logic [11:0] OFFS [6] = '{ddim_pkg::OFF_ISO_OR, ddim_pkg::OFF_PERIODIC_OR,
      ddim_pkg::OFF_ASYNC_OR, ddim_pkg::OFF_ISO_AND, ddim_pkg::OFF_PERIODIC_AND,
      ddim_pkg::OFF_ASYNC_AND};

   ddim_top #(.ADDR_W(12)) i_dut (
      .CLK_SYS(clk), .RST_N(rst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(ar_rdy),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .DONE_ISO(done[0]), .DONE_PERIODIC(done[1]),
      .DONE_ASYNC(done[2]), .IRQ(irq));

   // ==========================================================
   // Clock, timeout and helpers
   // ==========================================================
   // The clock toggles every half period.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // A hang is cut short after a generous number of cycles.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         print_verdict();
      end
   end

   // Next state of the pseudo-random generator.
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0000_0000);
   endfunction : lfsr

   // Expected group match of one list.
   function automatic logic match(input logic [31:0] d, input logic [31:0] o,
                                  input logic [31:0] a);
      return (|(d & o)) | ((|a) & ((d & a) == a));
   endfunction : match

   // Counts one comparison and reports a mismatch.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // One register write; address and data are offered together.
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awvalid && aw_rdy) awvalid <= 1'b0;
         if (wvalid && w_rdy) wvalid <= 1'b0;
      end while (!bvalid && n < 100);
      rsp = bresp;
      bready <= 1'b0;
      if (n >= 100) miscompares++;
   endtask : wr

   // One register read; data and response are taken at the handshake edge.
   task automatic rd(input logic [11:0] a);
      int n;
      n = 0;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arvalid && ar_rdy) arvalid <= 1'b0;
      end while (!rvalid && n < 100);
      rdv = rdata;
      rsp = rresp;
      rready <= 1'b0;
      if (n >= 100) miscompares++;
   endtask : rd

   // Programs one list's masks, raises its done map and checks the request.
   task automatic grp(input int i, input logic [31:0] om, input logic [31:0] am,
                      input logic [31:0] dn, input logic en);
      logic e;
      wr(OFFS[i], om, 4'hf);
      wr(OFFS[3+i], am, 4'hf);
      @(posedge clk);
      done[i] <= dn;
      repeat (3) @(posedge clk);
      e = en & match(dn, om, am);
      chk({31'h0, irq}, {31'h0, e});
      rd(ddim_pkg::OFF_IRQ_STATUS);
      chk({31'h0, rdv[ddim_pkg::LIST_BIT[i]]}, {31'h0, e});
      @(posedge clk);
      done[i] <= 32'h0;
      wr(ddim_pkg::OFF_IRQ_STATUS, ddim_pkg::EVENT_BITS, 4'hf);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
   endtask : grp

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      logic [31:0] v;
      logic [31:0] om;
      logic [31:0] am;
      logic [31:0] dn;
      rst_n = 1'b0; awaddr = 12'h0; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0;
      wvalid = 1'b0; bready = 1'b0; araddr = 12'h0; arvalid = 1'b0; rready = 1'b0;
      done[0] = 32'h0; done[1] = 32'h0; done[2] = 32'h0;
      seed = 32'h239b_1634; miscompares = 0; tests_run = 0; cycles = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      // Every mask reads zero after reset.
      for (int i = 0; i < 6; i++) begin
         rd(OFFS[i]);
         chk(rdv, ddim_pkg::MASK_RESET);
      end
      $display("Test reset values finished");
      // Random words are written and read back from every mask.
      for (int k = 0; k < 4; k++) begin
         for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            wr(OFFS[i], seed, 4'hf);
            chk({30'h0, rsp}, {30'h0, ddim_pkg::RESP_OKAY});
            rd(OFFS[i]);
            chk(rdv, seed);
            chk({30'h0, rsp}, {30'h0, ddim_pkg::RESP_OKAY});
         end
      end
      // Only strobed byte lanes change.
      v = lfsr(seed);
      wr(OFFS[0], 32'hffff_ffff, 4'hf);
      wr(OFFS[0], v, 4'h5);
      rd(OFFS[0]);
      chk(rdv, (v & 32'h00ff_00ff) | 32'hff00_ff00);
      // Unmapped and misaligned places are refused and leave the masks alone.
      wr(12'h100, v, 4'hf);
      chk({30'h0, rsp}, {30'h0, ddim_pkg::RESP_SLVERR});
      rd(12'h100);
      chk(rdv, 32'h0);
      chk({30'h0, rsp}, {30'h0, ddim_pkg::RESP_SLVERR});
      wr(12'h319, 32'h0, 4'hf);
      chk({30'h0, rsp}, {30'h0, ddim_pkg::RESP_SLVERR});
      rd(OFFS[0]);
      chk(rdv, (v & 32'h00ff_00ff) | 32'hff00_ff00);
      $display("Test register access finished");
      // Grouping conditions of every list, corner cases first.
      wr(ddim_pkg::OFF_IRQ_ENABLE, ddim_pkg::EVENT_BITS, 4'hf);
      wr(ddim_pkg::OFF_IRQ_MASK, ddim_pkg::EVENT_BITS, 4'hf);
      for (int i = 0; i < 3; i++) begin
         for (int t = 0; t < 8; t++) begin
            seed = lfsr(seed);
            v = lfsr(seed);
            om = 32'h0;
            am = seed | 32'h1;
            case (t)
               0: begin
                  am = 32'h0;
                  dn = 32'hffff_ffff;
               end
               1: dn = am;
               2: dn = am ^ 32'h1;
               3: begin
                  am = 32'h0;
                  om = 32'h1 << seed[4:0];
                  dn = om;
               end
               default: begin
                  om = seed & v & lfsr(v);
                  am = v & lfsr(v);
                  dn = seed | lfsr(lfsr(v));
               end
            endcase
            grp(i, om, am, dn, 1'b1);
         end
      end
      // A status bit held off the line by the interrupt mask stays quiet.
      wr(ddim_pkg::OFF_IRQ_MASK, 32'h0, 4'hf);
      wr(OFFS[2], 32'hffff_ffff, 4'hf);
      @(posedge clk);
      done[2] <= 32'h1;
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      wr(ddim_pkg::OFF_IRQ_MASK, ddim_pkg::EVENT_BITS, 4'hf);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      @(posedge clk);
      done[2] <= 32'h0;
      wr(ddim_pkg::OFF_IRQ_STATUS, ddim_pkg::EVENT_BITS, 4'hf);
      // With the list enables off no request is raised.
      wr(ddim_pkg::OFF_IRQ_ENABLE, 32'h0, 4'hf);
      for (int i = 0; i < 3; i++) begin
         grp(i, 32'hffff_ffff, 32'h0, 32'h8000_0000, 1'b0);
      end
      $display("Test grouping finished");
      print_verdict();
   end
endmodule : descriptor_done_irq_masks_tb
`default_nettype wire
